// *** pkg/scan_pkg.sv ***
// Shared constants and types for the boundary-scan test data registers.
// Assumes one test access port per device, with a three-bit instruction.
package scan_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_WIDTH = 3;
  localparam logic [IR_WIDTH-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_WIDTH-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_WIDTH-1:0] IR_SAMPLE = 3'h2;
  localparam logic [IR_WIDTH-1:0] IR_CLAMP = 3'h3;
  localparam logic [IR_WIDTH-1:0] IR_HIGHZ = 3'h4;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 3'h7;
  // Fixed pattern loaded in capture-IR, low two bits 01
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 3'h1;
  // Instruction that is current after test-logic-reset
  localparam logic [IR_WIDTH-1:0] IR_RESET = IR_IDCODE;

  // ----------------------------------------------------------------
  // Identification value layout
  // ----------------------------------------------------------------
  localparam int ID_WIDTH = 32;
  localparam int DEVICE_CODE_WIDTH = 15;
  localparam int MANUF_WIDTH = 11;
  // Revision takes whatever the fixed fields leave of the word
  localparam int REV_WIDTH = ID_WIDTH - DEVICE_CODE_WIDTH - MANUF_WIDTH - 1;
  localparam logic ID_FIXED_BIT = 1'h1;

  // ----------------------------------------------------------------
  // Bypass capture and reset values
  // ----------------------------------------------------------------
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic BYPASS_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SELECT_DR  = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SELECT_IR  = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_BYPASS   = 3'h1,
    SEL_BOUNDARY = 3'h2,
    SEL_IDENT    = 3'h4
  } dr_sel_t;

  typedef struct packed {
    logic drive_cells;
    logic float_outputs;
  } scan_mode_t;

endpackage : scan_pkg

// *** logic/level_sync.sv ***
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level; it is no word crossing.
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // No reset: the chain must pass a reset level through itself
  always_ff @(posedge clk) begin
    meta <= d;
  end

  always_ff @(posedge clk) begin
    q <= meta;
  end

endmodule : level_sync

// *** logic/scan_shift_reg.sv ***
// Test data register: serial shift path plus latched parallel output.
// Assumes capture, shift and update strobes from the test controller.
`timescale 1ns/1ns
module scan_shift_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic capture_en,
  input wire logic shift_en,
  input wire logic update_en,
  input wire logic [WIDTH-1:0] par_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic [WIDTH-1:0] par_out
);

  logic [WIDTH-1:0] stages;

  // ----------------------------------------------------------------
  // Shift path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stages <= INIT;
    end else if (capture_en) begin
      stages <= par_in;
    end else if (shift_en) begin
      stages <= {serial_in, stages[WIDTH-1:1]};
    end
  end

  assign serial_out = stages[0];

  // ----------------------------------------------------------------
  // Parallel latch
  // ----------------------------------------------------------------
  // Falling edge keeps the output still while the path shifts
  always_ff @(negedge clk) begin
    if (rst) begin
      par_out <= INIT;
    end else if (update_en) begin
      par_out <= stages;
    end
  end

endmodule : scan_shift_reg

// *** logic/scan_test_registers.sv ***
// Boundary-scan test port with its test data registers.
// Assumes the controller drives test clock, mode select and serial in.
`timescale 1ns/1ns
module scan_test_registers
  import scan_pkg::*;
#(
  parameter int NUM_PINS = 8,
  // Identity fields: arbitrary values
  parameter logic [REV_WIDTH-1:0] ID_REVISION = 5'h00,
  parameter logic [DEVICE_CODE_WIDTH-1:0] ID_DEVICE = 15'h0123,
  parameter logic [MANUF_WIDTH-1:0] ID_MANUF = 11'h055
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_shift_clock,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  output logic test_serial_out,
  output logic test_serial_out_en,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] core_in,
  output logic [ID_WIDTH-1:0] id_parallel_out
);

  // Cells: inputs low, then output data, then output enable controls
  localparam int BSR_WIDTH = 3 * NUM_PINS;

  localparam logic [ID_WIDTH-1:0] ID_VALUE =
    {ID_REVISION, ID_DEVICE, ID_MANUF, ID_FIXED_BIT};

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic tms);
    tap_state_t n;
    n = ST_RESET;
    case (s)
      ST_RESET: n = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: n = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_DR: n = tms ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: n = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_IR: n = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: n = tms ? ST_SELECT_DR : ST_IDLE;
      default: n = ST_RESET;
    endcase
    return n;
  endfunction : tap_next

  // Unlisted codes fall back to bypass so the chain length stays known
  function automatic dr_sel_t select_dr(input logic [IR_WIDTH-1:0] code,
                                        input tap_state_t s);
    dr_sel_t d;
    d = SEL_BYPASS;
    if (s == ST_RESET) begin
      d = SEL_IDENT;
    end else begin
      case (code)
        IR_SAMPLE: d = SEL_BOUNDARY;
        IR_EXTEST: d = SEL_BOUNDARY;
        IR_IDCODE: d = SEL_IDENT;
        IR_BYPASS: d = SEL_BYPASS;
        IR_CLAMP: d = SEL_BYPASS;
        IR_HIGHZ: d = SEL_BYPASS;
        default: d = SEL_BYPASS;
      endcase
    end
    return d;
  endfunction : select_dr

  function automatic scan_mode_t mode_of(input logic [IR_WIDTH-1:0] code);
    scan_mode_t m;
    m.drive_cells = (code == IR_EXTEST) || (code == IR_CLAMP);
    m.float_outputs = (code == IR_HIGHZ);
    return m;
  endfunction : mode_of

  // ----------------------------------------------------------------
  // Test clock domain: inputs
  // ----------------------------------------------------------------
  logic rst_t;
  logic [NUM_PINS-1:0] pin_in_t;
  logic [2*NUM_PINS-1:0] core_t;

  // Reset reaches the test side only while the test clock runs
  level_sync #(.WIDTH(1)) u_rst_sync (
    .clk(test_shift_clock),
    .d(rst),
    .q(rst_t)
  );

  level_sync #(.WIDTH(NUM_PINS)) u_pin_sync_t (
    .clk(test_shift_clock),
    .d(pin_in),
    .q(pin_in_t)
  );

  level_sync #(.WIDTH(2*NUM_PINS)) u_core_sync_t (
    .clk(test_shift_clock),
    .d({core_oe, core_out}),
    .q(core_t)
  );

  // ----------------------------------------------------------------
  // Test controller state
  // ----------------------------------------------------------------
  tap_state_t state;
  tap_state_t next_state;

  always_comb begin
    next_state = tap_next(state, test_mode_select);
  end

  always_ff @(posedge test_shift_clock) begin
    if (rst_t) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  logic shift_ir;

  assign capture_dr = (state == ST_CAPTURE_DR);
  assign shift_dr = (state == ST_SHIFT_DR);
  assign update_dr = (state == ST_UPDATE_DR);
  assign shift_ir = (state == ST_SHIFT_IR);

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] instr;

  always_ff @(posedge test_shift_clock) begin
    if (rst_t) begin
      ir_shift <= IR_CAPTURE;
    end else if (state == ST_CAPTURE_IR) begin
      ir_shift <= IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift <= {test_serial_in, ir_shift[IR_WIDTH-1:1]};
    end
  end

  // Falling edge, so the new instruction is current before the next rise
  always_ff @(negedge test_shift_clock) begin
    if (rst_t) begin
      instr <= IR_RESET;
    end else if (state == ST_RESET) begin
      instr <= IR_RESET;
    end else if (state == ST_UPDATE_IR) begin
      instr <= ir_shift;
    end
  end

  dr_sel_t dr_sel;

  assign dr_sel = select_dr(instr, state);

  // ----------------------------------------------------------------
  // Bypass register
  // ----------------------------------------------------------------
  logic bypass_stage;

  always_ff @(posedge test_shift_clock) begin
    if (rst_t) begin
      bypass_stage <= BYPASS_RESET;
    end else if (capture_dr && dr_sel == SEL_BYPASS) begin
      bypass_stage <= BYPASS_CAPTURE;
    end else if (shift_dr && dr_sel == SEL_BYPASS) begin
      bypass_stage <= test_serial_in;
    end
  end

  // ----------------------------------------------------------------
  // Boundary scan register
  // ----------------------------------------------------------------
  logic bsr_serial;
  logic [BSR_WIDTH-1:0] bsr_par;
  logic sel_bsr;

  assign sel_bsr = (dr_sel == SEL_BOUNDARY);

  // Capture samples pins and core drive; update feeds the pad muxes
  scan_shift_reg #(.WIDTH(BSR_WIDTH)) u_boundary (
    .clk(test_shift_clock),
    .rst(rst_t),
    .capture_en(capture_dr && sel_bsr),
    .shift_en(shift_dr && sel_bsr),
    .update_en(update_dr && sel_bsr),
    .par_in({core_t, pin_in_t}),
    .serial_in(test_serial_in),
    .serial_out(bsr_serial),
    .par_out(bsr_par)
  );

  // ----------------------------------------------------------------
  // Identification register
  // ----------------------------------------------------------------
  logic id_serial;
  logic sel_id;

  assign sel_id = (dr_sel == SEL_IDENT);

  scan_shift_reg #(.WIDTH(ID_WIDTH), .INIT(ID_VALUE)) u_ident (
    .clk(test_shift_clock),
    .rst(rst_t),
    .capture_en(capture_dr && sel_id),
    .shift_en(shift_dr && sel_id),
    .update_en(update_dr && sel_id),
    .par_in(ID_VALUE),
    .serial_in(test_serial_in),
    .serial_out(id_serial),
    .par_out(id_parallel_out)
  );

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic dr_serial;

  always_comb begin
    case (dr_sel)
      SEL_BOUNDARY: dr_serial = bsr_serial;
      SEL_IDENT: dr_serial = id_serial;
      SEL_BYPASS: dr_serial = bypass_stage;
      default: dr_serial = bypass_stage;
    endcase
  end

  // Launched on the falling edge so the controller samples a settled bit
  always_ff @(negedge test_shift_clock) begin
    if (rst_t) begin
      test_serial_out <= 1'h0;
      test_serial_out_en <= 1'h0;
    end else begin
      test_serial_out <= shift_ir ? ir_shift[0] : dr_serial;
      test_serial_out_en <= shift_ir || shift_dr;
    end
  end

  // ----------------------------------------------------------------
  // System clock domain: crossing back
  // ----------------------------------------------------------------
  scan_mode_t mode_c;
  logic [BSR_WIDTH-1:0] bsr_par_c;
  logic [NUM_PINS-1:0] pin_in_c;
  logic load_toggle;
  logic load_toggle_c;
  logic load_seen;

  // Mode and cells move only on these edges; the toggle marks a new word
  always_ff @(negedge test_shift_clock) begin
    if (rst_t) begin
      load_toggle <= 1'h0;
    end else if (state == ST_RESET || state == ST_UPDATE_IR || update_dr) begin
      load_toggle <= ~load_toggle;
    end
  end

  // Toggle and pins are independent levels; the word itself is not synced
  level_sync #(.WIDTH(NUM_PINS + 1)) u_pin_sync_c (
    .clk(clk),
    .d({load_toggle, pin_in}),
    .q({load_toggle_c, pin_in_c})
  );

  // Word is taken only after it has stood still for two system clocks
  always_ff @(posedge clk) begin
    load_seen <= load_toggle_c;
    if (rst) begin
      mode_c <= '0;
      bsr_par_c <= '0;
    end else if (load_seen != load_toggle_c) begin
      mode_c <= mode_of(instr);
      bsr_par_c <= bsr_par;
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else if (mode_c.float_outputs) begin
      pad_out <= core_out;
      pad_oe <= '0;
    end else if (mode_c.drive_cells) begin
      pad_out <= bsr_par_c[2*NUM_PINS-1:NUM_PINS];
      pad_oe <= bsr_par_c[3*NUM_PINS-1:2*NUM_PINS];
    end else begin
      pad_out <= core_out;
      pad_oe <= core_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_in <= '0;
    end else begin
      core_in <= pin_in_c;
    end
  end

endmodule : scan_test_registers

// *** verif/scan_test_registers_monitor.sv ***
// Checker for the scan test registers, on the top ports only.
// Assumes a standard TAP walk; state and instruction are shadowed here.
`timescale 1ns/1ns
module scan_test_registers_monitor
  import scan_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter logic [REV_WIDTH-1:0] ID_REVISION = 5'h00,
  parameter logic [DEVICE_CODE_WIDTH-1:0] ID_DEVICE = 15'h0000,
  parameter logic [MANUF_WIDTH-1:0] ID_MANUF = 11'h000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_shift_clock,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  input wire logic test_serial_out,
  input wire logic test_serial_out_en,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] core_in,
  input wire logic [ID_WIDTH-1:0] id_parallel_out
);
  // ------------------------------------------------------------
  // Shadow TAP
  // ------------------------------------------------------------
  // Next state, one nibble per state, for mode select low and high
  localparam logic [63:0] NEXT0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NEXT1 = 64'h2FEF_CC02_8785_5920;
  logic [3:0] st;
  logic [IR_WIDTH-1:0] ir_sh;
  logic [IR_WIDTH-1:0] ir;
  logic [ID_WIDTH-1:0] exp_id;
  logic byp;

  assign byp = !(ir == IR_EXTEST || ir == IR_IDCODE || ir == IR_SAMPLE);

  always_ff @(posedge test_shift_clock) begin
    if (rst) begin
      st <= 4'h0;
    end else begin
      st <= test_mode_select ? NEXT1[st*4 +: 4] : NEXT0[st*4 +: 4];
    end
  end

  // Seen at the edge leaving update; the design latches half a cycle early
  always_ff @(posedge test_shift_clock) begin
    if (rst || st == 4'h0) begin
      ir <= IR_RESET;
    end else if (st == 4'hF) begin
      ir <= ir_sh;
    end
  end

  always_ff @(posedge test_shift_clock) begin
    if (st == 4'hB) begin
      ir_sh <= {test_serial_in, ir_sh[IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge test_shift_clock) begin
    if (st == 4'h3 && ir == IR_IDCODE) begin
      exp_id <= {ID_REVISION, ID_DEVICE, ID_MANUF, ID_FIXED_BIT};
    end else if (st == 4'h4 && ir == IR_IDCODE) begin
      exp_id <= {test_serial_in, exp_id[ID_WIDTH-1:1]};
    end
  end

  a_en_in_shift: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    test_serial_out_en == (st == 4'h4 || st == 4'hB))
    else $error("serial out enable outside shift states");
  a_bypass_zero: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    (st == 4'h4 && $past(st) == 4'h3 && byp) |-> test_serial_out == 1'b0)
    else $error("bypass stage did not capture zero");
  a_bypass_delay: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    (st == 4'h4 && $past(st) == 4'h4 && byp)
      |-> test_serial_out == $past(test_serial_in))
    else $error("bypass path is not one stage");
  a_id_shift_out: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    (st == 4'h4 && ir == IR_IDCODE) |-> test_serial_out == exp_id[0])
    else $error("identification bit out of order");
  a_id_latch: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    (st == 4'h8 && ir == IR_IDCODE) |-> id_parallel_out == exp_id)
    else $error("identification latch differs from shifted data");
  a_id_hold: assert property (
    @(posedge test_shift_clock) disable iff (rst)
    !$stable(id_parallel_out) |-> st == 4'h8 && ir == IR_IDCODE)
    else $error("identification latch changed outside update");
  a_highz_pads: assert property (
    @(posedge clk) disable iff (rst)
    (ir == IR_HIGHZ) [*8] |-> pad_oe == '0)
    else $error("pad enabled under high impedance");
  a_sample_pads: assert property (
    @(posedge clk) disable iff (rst)
    (ir == IR_SAMPLE) [*8]
      |-> pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("sampling disturbed the pads");
endmodule : scan_test_registers_monitor

bind scan_test_registers scan_test_registers_monitor #(
  .NUM_PINS(NUM_PINS), .ID_REVISION(ID_REVISION),
  .ID_DEVICE(ID_DEVICE), .ID_MANUF(ID_MANUF)
) scan_test_registers_monitor_i (
  .clk(clk), .rst(rst), .test_shift_clock(test_shift_clock),
  .test_mode_select(test_mode_select), .test_serial_in(test_serial_in),
  .test_serial_out(test_serial_out),
  .test_serial_out_en(test_serial_out_en), .pin_in(pin_in),
  .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out),
  .pad_oe(pad_oe), .core_in(core_in), .id_parallel_out(id_parallel_out)
);

// *** verif/scan_controller_model.sv ***
// Scan controller model: makes the test clock and walks the TAP.
// Assumes one device on the chain; the clock stands low between frames.
`timescale 1ns/1ns
module scan_controller_model (
  output logic test_shift_clock,
  output logic test_mode_select,
  output logic test_serial_in,
  input wire logic test_serial_out
);
  initial begin
    test_shift_clock = 1'b0;
    test_mode_select = 1'b1;
    test_serial_in = 1'b0;
  end

  // One 30 ns period; output is taken just before the rising edge
  task automatic tick(input logic m, input logic d, output logic q);
    test_mode_select = m;
    test_serial_in = d;
    #13;
    q = test_serial_out;
    test_shift_clock = 1'b1;
    #15;
    test_shift_clock = 1'b0;
    #2;
  endtask : tick

  task automatic walk(input int n, input logic m);
    logic q;
    repeat (n) tick(m, 1'b0, q);
  endtask : walk

  // From idle and back to idle, LSB first
  task automatic scan(input logic ir_path, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir_path) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask : scan
endmodule : scan_controller_model

// *** verif/boundary_scan_test_registers_bench.sv ***
// Self-checking bench for the scan test registers.
// Assumes the package, the design and the controller model are compiled.
`timescale 1ns/1ns
module boundary_scan_test_registers_bench
  import scan_pkg::*;
;
  // Identity fields: arbitrary values
  localparam logic [REV_WIDTH-1:0] REV = 5'h03;
  localparam logic [14:0] DEV = 15'h0ABC;
  localparam logic [10:0] MAN = 11'h2D5;
  localparam logic [31:0] ID_EXP = {REV, DEV, MAN, ID_FIXED_BIT};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pin_in = 8'h5A;
  logic [7:0] core_out = 8'h96;
  logic [7:0] core_oe = 8'h0F;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] core_in;
  logic [31:0] id_par;
  int n_fail = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  scan_test_registers #(.ID_REVISION(REV), .ID_DEVICE(DEV), .ID_MANUF(MAN))
  scan_test_registers_i (
    .clk(clk), .rst(rst), .test_shift_clock(tck), .test_mode_select(tms),
    .test_serial_in(tdi), .test_serial_out(tdo), .test_serial_out_en(),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in),
    .id_parallel_out(id_par)
  );

  scan_controller_model scan_controller_model_i (
    .test_shift_clock(tck), .test_mode_select(tms),
    .test_serial_in(tdi), .test_serial_out(tdo)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic set_ir(input logic [2:0] code);
    logic [63:0] q;
    scan_controller_model_i.scan(1'b1, 3, 64'(code), q);
    chk(q, 64'(IR_CAPTURE));
  endtask : set_ir

  task automatic t_ident(input logic load);
    logic [63:0] q;
    if (load) begin
      set_ir(IR_IDCODE);
    end else begin
      scan_controller_model_i.walk(5, 1'b1);
      scan_controller_model_i.walk(1, 1'b0);
    end
    scan_controller_model_i.scan(1'b0, 32, 64'h6B1E_93C4, q);
    chk(q, 64'(ID_EXP));
    chk(64'(id_par), 64'h0000_0000_6B1E_93C4);
    $display("test ident done");
  endtask : t_ident

  // Preload the pads through sampling, then drive them in external test
  task automatic t_boundary();
    logic [63:0] q;
    set_ir(IR_SAMPLE);
    repeat (8) @(posedge clk);
    chk(64'({pad_oe, pad_out}), 64'h0F96);
    scan_controller_model_i.scan(1'b0, 32, 64'hFF3C_0081, q);
    chk(64'(q[7:0]), 64'h005A);
    chk(64'(q[31:24]), 64'h0081);
    @(posedge clk);
    pin_in <= 8'hC3;
    set_ir(IR_EXTEST);
    repeat (8) @(posedge clk);
    chk(64'({pad_oe, pad_out}), 64'hFF3C);
    chk(64'(core_in), 64'h00C3);
    scan_controller_model_i.scan(1'b0, 24, 64'h00FF_3C00, q);
    chk(64'(q[7:0]), 64'h00C3);
    $display("test boundary done");
  endtask : t_boundary

  task automatic t_bypass();
    logic [2:0] codes [4] = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, 3'h5};
    logic [63:0] q;
    foreach (codes[i]) begin
      set_ir(codes[i]);
      scan_controller_model_i.scan(1'b0, 8, 64'h00B6, q);
      chk(q, 64'h006C);
      repeat (8) @(posedge clk);
      if (codes[i] == IR_HIGHZ) chk(64'(pad_oe), 64'h0000);
      if (codes[i] == IR_CLAMP) chk(64'({pad_oe, pad_out}), 64'hFF3C);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Test side needs its clock running while reset is held
  initial begin
    repeat (4) @(posedge clk);
    scan_controller_model_i.walk(5, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    scan_controller_model_i.walk(3, 1'b1);
    t_ident(1'b0);
    t_boundary();
    t_bypass();
    t_ident(1'b1);
    t_ident(1'b0);
    give_verdict();
  end

  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule : boundary_scan_test_registers_bench
